// ---- rtl/rgb2_pkg.sv ----
/*
 * Constants, register map and types for the group-two tricolor
 * pattern generator. Assumes a single 20 MHz clock and byte-wide
 * register writes already decoded from the two-wire serial bus.
 */
package rgb2_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int BASE_PERIOD_US = 62_500;       // shortest period, 0.0625 s
  localparam int HALF_STEPS = 128;              // two half-steps per step
  // half-step at the shortest period, so integer division rounds down
  localparam int HALF_STEP_CYCLES_DEF =
    BASE_PERIOD_US * (CLK_HZ / 1_000_000) / HALF_STEPS;
  localparam int STEPS_PER_PERIOD = 64;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RED2_FADE_SLOPES = 8'h20;
  localparam logic [7:0] ADDR_GREEN2_FADE_SLOPES = 8'h21;
  localparam logic [7:0] ADDR_BLUE2_FADE_SLOPES = 8'h22;
  localparam logic [7:0] ADDR_GROUP2_GRADATION_CTRL = 8'h23;
  localparam logic [7:0] ADDR_GROUP2_PULSE_CTRL = 8'h24;
  localparam logic [7:0] ADDR_RED2_OFF_POSITION = 8'h25;
  localparam logic [7:0] ADDR_RED2_ON_POSITION = 8'h26;
  localparam logic [7:0] ADDR_GREEN2_OFF_POSITION = 8'h27;
  localparam logic [7:0] ADDR_GREEN2_ON_POSITION = 8'h28;
  localparam logic [7:0] ADDR_BLUE2_OFF_POSITION = 8'h29;
  localparam logic [7:0] ADDR_BLUE2_ON_POSITION = 8'h2A;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FADE_IN_LSB = 0;
  localparam int FADE_OUT_LSB = 3;
  localparam int PERIOD_SEL_LSB = 0;
  localparam int AUTO_ONOFF_BIT = 3;
  localparam int RUN_ONCE_BIT = 4;
  localparam int RED_HALF_BIT = 5;              // green 6, blue 7
  localparam int HOLD_LSB = 0;
  localparam int FLASH_LSB = 3;
  localparam int PULSE_MODE_BIT = 6;
  localparam logic [7:0] POS_ALL_ON = 8'hFF;
  localparam logic [5:0] ELAPSED_SAT = 6'h3F;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FLASH = 2'b01,
    SEQ_HOLD = 2'b11,
    SEQ_DONE = 2'b10
  } seq_state_t;

  // slope length in steps; the maximum is half of the 64-step period
  function automatic logic [5:0] slope_steps(input logic [2:0] code);
    logic [5:0] s;
    s = 6'h00;
    case (code)
      3'h1: s = 6'h02;                          // 1/16
      3'h2: s = 6'h04;                          // 1/8
      3'h3: s = 6'h08;                          // 1/4
      3'h4: s = 6'h0C;                          // 3/8
      3'h5: s = 6'h10;                          // 1/2
      3'h6: s = 6'h18;                          // 3/4
      3'h7: s = 6'h20;                          // maximum
      default: s = 6'h00;                       // no slope
    endcase
    return s;
  endfunction

endpackage

// ---- rtl/rgb2_timebase.sv ----
/*
 * Step time base for group two: 128 half-steps per on/off period.
 * Assumes run is held high for as long as the sequence is active.
 */
`timescale 1ns/100ps
module rgb2_timebase
  import rgb2_pkg::*;
#(
  parameter int HALF_STEP_CYCLES = HALF_STEP_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] period_sel,
  output logic tick,
  output logic [6:0] half_idx,
  output logic period_end
);

  logic [23:0] cnt_q;
  logic [23:0] limit;
  logic started_q;

  // each code doubles the period
  assign limit = (24'(HALF_STEP_CYCLES) << period_sel) - 24'h000001;

  // ----------------------------------------------------------------
  // half-step divider
  // ----------------------------------------------------------------
  // first tick fires at start so step 0 edge is seen at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      cnt_q <= 24'h000000;
      half_idx <= 7'h00;
      tick <= 1'b0;
      started_q <= 1'b0;
      period_end <= 1'b0;
    end else begin
      tick <= 1'b0;
      period_end <= 1'b0;
      if (!started_q) begin
        started_q <= 1'b1;
        tick <= 1'b1;
      end else if (cnt_q == limit) begin
        cnt_q <= 24'h000000;
        half_idx <= 7'(half_idx + 7'h01);
        tick <= 1'b1;
        period_end <= (half_idx == 7'h7F);
      end else begin
        cnt_q <= 24'(cnt_q + 24'h000001);
      end
    end
  end

endmodule

// ---- rtl/rgb2_channel.sv ----
/*
 * One group-two LED channel: position waveform with fade ramps.
 * Assumes tick and half_idx come from the shared time base.
 */
`timescale 1ns/100ps
module rgb2_channel
  import rgb2_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [6:0] half_idx,
  input wire logic half_mode,
  input wire logic pulse_mode,
  input wire logic [7:0] on_pos,
  input wire logic [7:0] off_pos,
  input wire logic [2:0] fin_code,
  input wire logic [2:0] fout_code,
  input wire logic [4:0] pwm_phase,
  output logic led_out,
  output logic fade_done
);

  logic [5:0] step;
  logic boundary;
  logic wave_q;
  logic wave_d;
  logic [5:0] elapsed_q;
  logic [5:0] s_in;
  logic [5:0] s_out;
  logic [10:0] duty_in;
  logic [10:0] duty_out;
  logic lit;

  // half mode runs the 64 steps twice per period
  assign step = half_mode ? half_idx[5:0] : half_idx[6:1];
  assign boundary = run && tick && (half_mode || !half_idx[0]);
  assign s_in = slope_steps(fin_code);
  assign s_out = slope_steps(fout_code);

  // position compare at the rising edge of each step clock
  always_comb begin
    wave_d = wave_q;
    if (on_pos == off_pos) begin
      wave_d = (on_pos == POS_ALL_ON);
    end else if (step == on_pos[5:0]) begin
      wave_d = 1'b1;
    end else if (step == off_pos[5:0]) begin
      wave_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      wave_q <= 1'b0;
    end else if (boundary) begin
      wave_q <= wave_d;
    end
  end

  // steps since the last edge; starts saturated so no false fade-out
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      elapsed_q <= ELAPSED_SAT;
    end else if (boundary) begin
      if (wave_d != wave_q) begin
        elapsed_q <= 6'h00;
      end else if (elapsed_q != ELAPSED_SAT) begin
        elapsed_q <= 6'(elapsed_q + 6'h01);
      end
    end
  end

  // ramp by comparing a fast phase against elapsed/slope
  assign duty_in = 11'(pwm_phase) * 11'(s_in);
  assign duty_out = 11'(pwm_phase) * 11'(s_out);

  always_comb begin
    if (wave_q) begin
      lit = pulse_mode || (s_in == 6'h00) || (elapsed_q >= s_in) ||
            (duty_in < 11'({elapsed_q, 5'h00}));
    end else begin
      lit = !pulse_mode && (elapsed_q < s_out) &&
            (duty_out < 11'({6'(s_out - elapsed_q), 5'h00}));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      led_out <= 1'b0;
    end else begin
      led_out <= run && lit;
    end
  end

  // end of a ramp in either direction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fade_done <= 1'b0;
    end else begin
      fade_done <= boundary && !pulse_mode && (wave_d == wave_q) &&
        ((wave_q && s_in != 6'h00 && 6'(elapsed_q + 6'h01) == s_in) ||
         (!wave_q && s_out != 6'h00 && 6'(elapsed_q + 6'h01) == s_out));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_all_on_equal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    boundary && on_pos == off_pos && on_pos == POS_ALL_ON |=> wave_q)
    else $error("equal FF positions did not turn output on");

  chk_all_off_equal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    boundary && on_pos == off_pos && on_pos != POS_ALL_ON |=> !wave_q)
    else $error("equal positions did not turn output off");

  chk_on_edge_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    boundary && on_pos != off_pos && step == on_pos[5:0] |=> wave_q)
    else $error("output not on at on position");

  chk_pulse_mode_hard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run && pulse_mode && wave_q && $stable(run) |=> led_out)
    else $error("pulse mode output not fully on");

endmodule

// ---- rtl/rgb2_pattern_gen.sv ----
/*
 * Group-two tricolor pattern generator: byte register file, gradation
 * sequencer and three channel waveform generators.
 * Assumes the two-wire serial slave presents each decoded register
 * write as a one-cycle strobe with address and data, on ref_clk.
 */
`timescale 1ns/100ps

module rgb2_pattern_gen
  import rgb2_pkg::*;
#(
  parameter int HALF_STEP_CYCLES = HALF_STEP_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic red_out_g2,
  output logic green_out_g2,
  output logic blue_out_g2,
  output logic fade_done_irq,
  output logic gradation_done_irq
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // per-channel arrays, index 0 red, 1 green, 2 blue
  logic [7:0] fade_slopes_q [3];
  logic [7:0] off_position_q [3];
  logic [7:0] on_position_q [3];
  logic [7:0] group2_gradation_ctrl_q;
  logic [7:0] group2_pulse_ctrl_q;
  logic grad_wr;

  assign grad_wr = reg_wr_en && (reg_addr == ADDR_GROUP2_GRADATION_CTRL);

  // shared control registers; writes to other offsets are ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      group2_gradation_ctrl_q <= REG_RESET;
      group2_pulse_ctrl_q <= REG_RESET;
    end else if (reg_wr_en) begin
      if (reg_addr == ADDR_GROUP2_GRADATION_CTRL) begin
        group2_gradation_ctrl_q <= reg_wdata;
      end
      if (reg_addr == ADDR_GROUP2_PULSE_CTRL) begin
        group2_pulse_ctrl_q <= reg_wdata;
      end
    end
  end

  // per-channel registers; positions keep all 8 bits so FF is visible
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        fade_slopes_q[i] <= REG_RESET;
        off_position_q[i] <= REG_RESET;
        on_position_q[i] <= REG_RESET;
      end
    end else if (reg_wr_en) begin
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == 8'(ADDR_RED2_FADE_SLOPES + 8'(i))) begin
          fade_slopes_q[i] <= reg_wdata;
        end
        if (reg_addr == 8'(ADDR_RED2_OFF_POSITION + 8'(2 * i))) begin
          off_position_q[i] <= reg_wdata;
        end
        if (reg_addr == 8'(ADDR_RED2_ON_POSITION + 8'(2 * i))) begin
          on_position_q[i] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  logic [2:0] auto_period_sel;
  logic auto_onoff_en;
  logic gradation_run_once;
  logic [2:0] half_period;
  logic [2:0] hold_periods;
  logic [2:0] flash_count;
  logic pulse_mode_en;

  assign auto_period_sel =
    group2_gradation_ctrl_q[PERIOD_SEL_LSB +: 3];
  assign auto_onoff_en = group2_gradation_ctrl_q[AUTO_ONOFF_BIT];
  assign gradation_run_once = group2_gradation_ctrl_q[RUN_ONCE_BIT];
  assign half_period = group2_gradation_ctrl_q[RED_HALF_BIT +: 3];
  assign hold_periods = group2_pulse_ctrl_q[HOLD_LSB +: 3];
  assign flash_count = group2_pulse_ctrl_q[FLASH_LSB +: 3];
  assign pulse_mode_en = group2_pulse_ctrl_q[PULSE_MODE_BIT];

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic tb_run;
  logic tick;
  logic [6:0] half_idx;
  logic period_end;
  seq_state_t seq_q;
  logic [2:0] period_cnt_q;

  assign tb_run = (seq_q == SEQ_FLASH) || (seq_q == SEQ_HOLD);

  rgb2_timebase #(
    .HALF_STEP_CYCLES(HALF_STEP_CYCLES)
  ) u_timebase (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(tb_run),
    .period_sel(auto_period_sel),
    .tick(tick),
    .half_idx(half_idx),
    .period_end(period_end)
  );

  // ----------------------------------------------------------------
  // gradation sequencer
  // ----------------------------------------------------------------
  logic seq_finish;

  // last period of flashing with no hold, or last hold period
  assign seq_finish = period_end &&
    (((seq_q == SEQ_FLASH) && (period_cnt_q == flash_count) &&
      (hold_periods == 3'h0)) ||
     ((seq_q == SEQ_HOLD) && (period_cnt_q == 3'(hold_periods - 3'h1))));

  // a write to the gradation register restarts from idle so that the
  // new period and mode take effect from a clean step 0
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seq_q <= SEQ_IDLE;
      period_cnt_q <= 3'h0;
    end else if (grad_wr || !auto_onoff_en) begin
      seq_q <= SEQ_IDLE;
      period_cnt_q <= 3'h0;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          seq_q <= SEQ_FLASH;
          period_cnt_q <= 3'h0;
        end
        SEQ_FLASH: begin
          if (period_end) begin
            if (period_cnt_q != flash_count) begin
              period_cnt_q <= 3'(period_cnt_q + 3'h1);
            end else if (hold_periods != 3'h0) begin
              seq_q <= SEQ_HOLD;
              period_cnt_q <= 3'h0;
            end else begin
              seq_q <= gradation_run_once ? SEQ_DONE : SEQ_FLASH;
              period_cnt_q <= 3'h0;
            end
          end
        end
        SEQ_HOLD: begin
          if (period_end) begin
            if (seq_finish) begin
              seq_q <= gradation_run_once ? SEQ_DONE : SEQ_FLASH;
              period_cnt_q <= 3'h0;
            end else begin
              period_cnt_q <= 3'(period_cnt_q + 3'h1);
            end
          end
        end
        SEQ_DONE: begin
          seq_q <= SEQ_DONE;                    // waits for re-enable
        end
        default: begin
          seq_q <= SEQ_IDLE;
          period_cnt_q <= 3'h0;
        end
      endcase
    end
  end

  // completion pulse; a restarting write drops the pending event
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gradation_done_irq <= 1'b0;
    end else begin
      gradation_done_irq <= seq_finish && auto_onoff_en && !grad_wr;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [4:0] pwm_phase_q;
  logic [2:0] led_out;
  logic [2:0] ch_fade_done;

  // free-running ramp phase, fast against any step
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_phase_q <= 5'h00;
    end else begin
      pwm_phase_q <= 5'(pwm_phase_q + 5'h01);
    end
  end

  // one identical generator per colour
  for (genvar c = 0; c < 3; c++) begin : g_chan
    rgb2_channel u_chan (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(seq_q == SEQ_FLASH),
      .tick(tick),
      .half_idx(half_idx),
      .half_mode(half_period[c]),
      .pulse_mode(pulse_mode_en),
      .on_pos(on_position_q[c]),
      .off_pos(off_position_q[c]),
      .fin_code(fade_slopes_q[c][FADE_IN_LSB +: 3]),
      .fout_code(fade_slopes_q[c][FADE_OUT_LSB +: 3]),
      .pwm_phase(pwm_phase_q),
      .led_out(led_out[c]),
      .fade_done(ch_fade_done[c])
    );
  end

  assign red_out_g2 = led_out[0];
  assign green_out_g2 = led_out[1];
  assign blue_out_g2 = led_out[2];

  // any colour finishing a ramp raises the group event
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fade_done_irq <= 1'b0;
    end else begin
      fade_done_irq <= |ch_fade_done;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_grad_write_store: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    grad_wr |=> group2_gradation_ctrl_q == $past(reg_wdata))
    else $error("gradation register write lost");

  chk_auto_off_dark: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (!auto_onoff_en)[*3] |-> !red_out_g2 && !green_out_g2 && !blue_out_g2)
    else $error("output lit with automatic on/off disabled");

  chk_run_once_stop: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    seq_finish && gradation_run_once && auto_onoff_en && !grad_wr
    |=> seq_q == SEQ_DONE ##1 seq_q == SEQ_DONE)
    else $error("run-once sequence did not stop");

  chk_flash_wrap: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    seq_q == SEQ_FLASH && period_end && period_cnt_q == flash_count &&
    auto_onoff_en && !grad_wr
    |=> period_cnt_q == 3'h0 && seq_q != SEQ_IDLE)
    else $error("flash count did not end flashing");

  chk_hold_done: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    seq_q == SEQ_HOLD && period_end &&
    period_cnt_q == 3'(hold_periods - 3'h1) && auto_onoff_en && !grad_wr
    |=> gradation_done_irq ##1 !gradation_done_irq)
    else $error("hold end not flagged as one pulse");

  chk_fade_flag: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(ch_fade_done[0]) |=> fade_done_irq)
    else $error("red fade end not flagged");

endmodule

// ---- verif/rgb2_host.sv ----
/*
 * Host model: byte register writes into the group-two generator.
 * Assumes writes are only requested after reset has been released.
 */
`timescale 1ns/100ps
module rgb2_host (
  input wire logic ref_clk,
  output logic reg_wr_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // ----------------------------------------
  // write strobe
  // ----------------------------------------
  // idle bus shows inverted values, never a stale copy
  initial begin
    reg_wr_en = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'hFF;
  end

  // one strobe per byte, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ---- verif/rgb2_pattern_gen_tb.sv ----
/*
 * Self-checking bench for the group-two pattern generator.
 * Assumes a shortened time base of four cycles per half-step.
 */
`timescale 1ns/100ps
module rgb2_pattern_gen_tb;
  import rgb2_pkg::*;
  // ----------------------------------------
  // setup
  // ----------------------------------------
  localparam int HSC = 4;
  localparam int PER = 128 * HSC; // cycles per period, code 0
  localparam int TOL = 16; // sequencer overhead per loop
  logic ref_clk;
  logic rst_n;
  logic reg_wr_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic red_out_g2, green_out_g2, blue_out_g2;
  logic fade_done_irq, gradation_done_irq;
  int failures;
  int num_checks;
  int rc, gc, bc, gr, fd, gd;

  rgb2_pattern_gen #(.HALF_STEP_CYCLES(HSC)) u_rgb2_pattern_gen (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .red_out_g2(red_out_g2), .green_out_g2(green_out_g2),
    .blue_out_g2(blue_out_g2), .fade_done_irq(fade_done_irq),
    .gradation_done_irq(gradation_done_irq)
  );

  rgb2_host u_rgb2_host (
    .ref_clk(ref_clk), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );

  // free-running 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] near(input int a, input int e);
    return (a >= e - TOL && a <= e + TOL) ? 16'h0001 : 16'h0000;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_rgb2_host.wr(a, d);
  endtask

  // lit cycles, green rises and events over n cycles
  task automatic meas(input int n);
    logic gp;
    rc = 0;
    gc = 0;
    bc = 0;
    gr = 0;
    fd = 0;
    gd = 0;
    gp = green_out_g2;
    repeat (n) begin
      @(posedge ref_clk);
      #2;
      rc += (red_out_g2 === 1'b1);
      gc += (green_out_g2 === 1'b1);
      bc += (blue_out_g2 === 1'b1);
      gr += (green_out_g2 === 1'b1 && gp === 1'b0);
      gp = green_out_g2;
      fd += (fade_done_irq === 1'b1);
      gd += (gradation_done_irq === 1'b1);
    end
  endtask

  // cycles between two completion pulses, bounded both ways
  task automatic gap(output int g);
    int w;
    w = 0;
    g = 0;
    while (gradation_done_irq !== 1'b1 && w < 20000) begin
      @(posedge ref_clk);
      #2;
      w++;
    end
    do begin
      @(posedge ref_clk);
      #2;
      g++;
    end while (gradation_done_irq !== 1'b1 && g < 20000);
    // a missing pulse is a mismatch, not just a bad gap
    if (w >= 20000 || g >= 20000) begin
      failures++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // disabled after reset; unmapped writes must not light anything
  task automatic s_reset();
    chk({11'h000, red_out_g2, green_out_g2, blue_out_g2,
         fade_done_irq, gradation_done_irq}, 16'h0000);
    wr(8'h26, 8'h10);
    wr(8'h25, 8'h3F);
    wr(8'h28, 8'hFF);
    wr(8'h27, 8'hFF);
    wr(8'h2A, 8'h05);
    wr(8'h29, 8'h05);
    wr(8'h2B, 8'hFF);
    wr(8'h1F, 8'hFF);
    meas(PER);
    chk(16'(rc + gc + bc), 16'h0000);
  endtask

  // on step 16 to off step 63; equal positions FF and not FF
  task automatic s_wave();
    wr(8'h23, 8'h08);
    repeat (8) @(posedge ref_clk);
    meas(4 * PER);
    chk(near(rc, 4 * 47 * 8), 16'h0001);
    chk(near(gc, 4 * PER), 16'h0001);
    chk(16'(bc), 16'h0000);
  endtask

  // green in half-period mode lights twice per period
  task automatic s_half();
    wr(8'h28, 8'h00);
    wr(8'h27, 8'h20);
    wr(8'h23, 8'h48);
    repeat (8) @(posedge ref_clk);
    meas(4 * PER);
    chk(16'(gr inside {[7:9]}), 16'h0001);
    chk(near(gc, 4 * 256), 16'h0001);
    chk(near(rc, 4 * 47 * 8), 16'h0001);
  endtask

  // period doubles with each code step
  task automatic s_period();
    int g;
    for (int c = 0; c < 3; c++) begin
      wr(8'h23, 8'h08 | 8'(c));
      gap(g);
      chk(near(g, PER << c), 16'h0001);
    end
  endtask

  // flash count plus one, then hold periods
  task automatic s_seq();
    int g;
    logic [7:0] pv [2] = '{8'h12, 8'h3F};
    int np [2] = '{5, 15};
    for (int i = 0; i < 2; i++) begin
      wr(8'h24, pv[i]);
      wr(8'h23, 8'h08);
      gap(g);
      chk(near(g, np[i] * PER), 16'h0001);
    end
  endtask

  // run once: a single period and a single completion
  task automatic s_once();
    wr(8'h24, 8'h00);
    wr(8'h23, 8'h18);
    meas(3 * PER);
    chk(16'(gd), 16'h0001);
    chk(near(rc, 47 * 8), 16'h0001);
  endtask

  // each fade field except red fade-in completes; pulse mode suppresses fades
  task automatic s_fade();
    logic [7:0] fa [5] = '{8'h20, 8'h21, 8'h21, 8'h22, 8'h22};
    logic [7:0] fv [5] = '{8'h20, 8'h07, 8'h08, 8'h06, 8'h30};
    // every ramp must fit inside its on or off span to complete
    wr(8'h27, 8'h30);
    wr(8'h2A, 8'h08);
    wr(8'h29, 8'h28);
    for (int i = 0; i < 5; i++) begin
      wr(fa[i], fv[i]);
      wr(8'h23, 8'h08);
      meas(2 * PER);
      chk(16'(fd > 0), 16'h0001);
      wr(fa[i], 8'h00);
    end
    wr(8'h20, 8'h20);
    wr(8'h24, 8'h40);
    wr(8'h23, 8'h08);
    meas(2 * PER);
    chk(16'(fd), 16'h0000);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic test_done();
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, well beyond the expected run length
  initial begin
    #(60000 * 50);
    failures++;
    test_done();
  end

  // reset, scenarios, then a mid-run reset
  initial begin
    failures = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    s_reset();
    s_wave();
    s_half();
    s_period();
    s_seq();
    s_once();
    s_fade();
    @(posedge ref_clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    chk({13'h0000, red_out_g2, green_out_g2, blue_out_g2}, 16'h0000);
    test_done();
  end
endmodule
